// File: shared/ucg_cfg.svh
`ifndef UCG_CFG_SVH
`define UCG_CFG_SVH

// ------------------------------------------------------------
// divisor, ratio and sync delay constants
// ------------------------------------------------------------
`define UCG_DIV_W 12
`define UCG_DIV_RESET 12'h000
`define UCG_RATIO_NORMAL 5'h10
`define UCG_RATIO_DOUBLE 5'h08
`define UCG_RATIO_SYNC 5'h02
`define UCG_SYNC_DELAY 2

`endif

// File: shared/ucg_pkg.sv
package ucg_pkg;
    // clock modes of the generator
    typedef enum logic [1:0] {
        UCG_ASYNC_NORMAL = 2'b00,
        UCG_ASYNC_DOUBLE = 2'b01,
        UCG_SYNC_MASTER = 2'b10,
        UCG_SYNC_SLAVE = 2'b11
    } ucg_mode_t;
endpackage

// File: core/ucg_edge_detect.sv
`timescale 1ns/1ns
`default_nettype none
`include "ucg_cfg.svh"

// ------------------------------------------------------------
// synchroniser and edge detector for the external transfer clock
// ------------------------------------------------------------
module ucg_edge_detect (
    input wire logic core_clk_i, // system clock
    input wire logic reset_i, // synchronous reset
    input wire logic xclk_i, // raw external transfer clock
    output logic level_o, // synchronised level
    output logic rise_o, // one-cycle pulse on rising edge
    output logic fall_o // one-cycle pulse on falling edge
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    // two-stage synchroniser; meta_r feeds only sync_r
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= xclk_i;
            sync_r <= meta_r;
        end
    end

    // previous synchronised value for edge detection
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= sync_r;
        end
    end

    assign level_o = sync_r;
    assign rise_o = sync_r & ~prev_r; // R18
    assign fall_o = ~sync_r & prev_r; // R18
endmodule // ucg_edge_detect

`default_nettype wire

// File: core/ucg_clock_gen.sv
// Functional notes
// R1: four modes; one bit picks async or sync
// R2: double rate acts only in async mode
// R3: in sync, pin direction picks master or slave
// R4: transfer clock pin idle in async modes
// R5: counter reloads at zero or low-byte write
// R6: one tick each time counter hits zero; code gives none when a low-byte write falls in that cycle
// R7: divisor is twelve bits, low and high
// R8: transmit divides tick by 16, 8 or 2
// R9: receiver takes tick, 16/8/2 state machine
// R10: double speed gives eight samples per bit
// R11: software keeps double rate zero in sync
// R12: slave clock synchronised then edge detected
// R13: external clock below quarter system clock
// R14: external clock keeps frequency margin
// R15: master drives pin, slave takes it in
// R16: sample on edge opposite to change edge
// R17: polarity zero: change rise, sample fall
// R18: one-cycle enable per qualifying clock edge
`timescale 1ns/1ns
`default_nettype none
`include "ucg_cfg.svh"

module ucg_clock_gen #(
    parameter int DIV_W = `UCG_DIV_W // divisor width
) (
    input wire logic core_clk_i, // system clock, 100 MHz
    input wire logic reset_i, // synchronous reset, high
    input wire logic sync_mode_select_i, // 0 async, 1 sync
    input wire logic double_rate_bit_i, // double speed in async
    input wire logic transfer_clock_dir_i, // 1 master (pin out)
    input wire logic clock_edge_polarity_i, // sync edge select
    input wire logic [7:0] baud_divisor_low_i, // divisor bits 7:0
    input wire logic [3:0] baud_divisor_high_i, // divisor bits 11:8
    input wire logic baud_divisor_low_wr_i, // low byte write strobe
    input wire logic transfer_clock_pin_i, // pin input level
    output logic transfer_clock_pin_o, // pin output level
    output logic transfer_clock_pin_oe_o, // pin output enable
    output logic [1:0] mode_o, // current clock mode
    output logic baud_tick_o, // rx base clock enable
    output logic tx_clk_en_o, // tx bit clock enable
    output logic rx_sample_en_o, // sync rx sample enable
    output logic [4:0] rx_states_o, // rx recovery state count
    output logic [DIV_W-1:0] baud_count_o // counter state
);
    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    ucg_pkg::ucg_mode_t mode;
    logic [DIV_W-1:0] divisor;
    logic [DIV_W-1:0] cnt_r;
    logic tick_r;
    logic [3:0] txdiv_r;
    logic xck_r;
    logic tx_en_r;
    logic rx_en_r;
    logic ext_rise;
    logic ext_fall;
    logic [4:0] ratio;

    // mode from select, direction and double-rate bits
    always_comb begin
        if (!sync_mode_select_i) begin // R1
            mode = double_rate_bit_i ? ucg_pkg::UCG_ASYNC_DOUBLE : ucg_pkg::UCG_ASYNC_NORMAL; // R2
        end else begin
            // double rate ignored here; software keeps it zero
            mode = transfer_clock_dir_i ? ucg_pkg::UCG_SYNC_MASTER : ucg_pkg::UCG_SYNC_SLAVE; // R3
        end
    end

    // states per bit, shared by transmitter and receiver
    function automatic logic [4:0] ratio_of(input ucg_pkg::ucg_mode_t m);
        unique case (m)
            ucg_pkg::UCG_ASYNC_NORMAL: ratio_of = `UCG_RATIO_NORMAL;
            ucg_pkg::UCG_ASYNC_DOUBLE: ratio_of = `UCG_RATIO_DOUBLE; // R10
            ucg_pkg::UCG_SYNC_MASTER: ratio_of = `UCG_RATIO_SYNC;
            ucg_pkg::UCG_SYNC_SLAVE: ratio_of = `UCG_RATIO_SYNC;
        endcase
    endfunction

    assign ratio = ratio_of(mode);
    assign rx_states_o = ratio; // R9
    assign mode_o = mode;
    assign divisor = DIV_W'({baud_divisor_high_i, baud_divisor_low_i}); // R7

    // ------------------------------------------------------------
    // baud rate generator
    // ------------------------------------------------------------
    // down-counter; a low-byte write restarts the period at once
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            cnt_r <= DIV_W'(`UCG_DIV_RESET);
        end else if (baud_divisor_low_wr_i || cnt_r == '0) begin
            cnt_r <= divisor; // R5
        end else begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    // tick on reaching zero gives fosc/(divisor+1)
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            tick_r <= 1'b0;
        end else begin
            tick_r <= (cnt_r == '0) && !baud_divisor_low_wr_i; // R6
        end
    end

    assign baud_tick_o = tick_r; // R9
    assign baud_count_o = cnt_r;

    // ------------------------------------------------------------
    // transmitter prescaler
    // ------------------------------------------------------------
    // counts ticks; wraps at ratio-1 so the tx bit rate is tick/ratio
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            txdiv_r <= 4'h0;
        end else if (mode == ucg_pkg::UCG_SYNC_SLAVE) begin
            txdiv_r <= 4'h0;
        end else if (tick_r) begin
            if ({1'b0, txdiv_r} >= ratio - 5'h01) begin
                txdiv_r <= 4'h0; // R8
            end else begin
                txdiv_r <= txdiv_r + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // transfer clock pin
    // ------------------------------------------------------------
    // master clock toggles on every baud tick, so one pin period spans two ticks
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            xck_r <= 1'b0;
        end else if (mode != ucg_pkg::UCG_SYNC_MASTER) begin
            xck_r <= 1'b0;
        end else if (tick_r) begin
            xck_r <= ~xck_r; // R15
        end
    end

    // idle level follows polarity so the first edge is a change edge
    assign transfer_clock_pin_o = xck_r ^ clock_edge_polarity_i;
    assign transfer_clock_pin_oe_o = (mode == ucg_pkg::UCG_SYNC_MASTER); // R4 R15

    ucg_edge_detect u_edge (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .xclk_i(transfer_clock_pin_i & sync_mode_select_i & ~transfer_clock_dir_i), // R4 R12
        .level_o(),
        .rise_o(ext_rise),
        .fall_o(ext_fall)
    );

    // ------------------------------------------------------------
    // bit enables
    // ------------------------------------------------------------
    // polarity 0: change on rise, sample on fall; 1 reverses it
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            tx_en_r <= 1'b0;
            rx_en_r <= 1'b0;
        end else begin
            unique case (mode)
                ucg_pkg::UCG_SYNC_SLAVE: begin
                    // slave edges arrive about three cycles late; peer must stay below fosc/4
                    tx_en_r <= clock_edge_polarity_i ? ext_fall : ext_rise; // R12 R13 R17
                    rx_en_r <= clock_edge_polarity_i ? ext_rise : ext_fall; // R16 R17
                end
                ucg_pkg::UCG_SYNC_MASTER: begin
                    // internal clock rises when xck_r goes high before polarity flip
                    tx_en_r <= tick_r & ~xck_r; // R17
                    rx_en_r <= tick_r & xck_r; // R16
                end
                default: begin
                    tx_en_r <= tick_r && ({1'b0, txdiv_r} >= ratio - 5'h01); // R8
                    rx_en_r <= 1'b0;
                end
            endcase
        end
    end

    assign tx_clk_en_o = tx_en_r;
    assign rx_sample_en_o = rx_en_r;

endmodule // ucg_clock_gen

`default_nettype wire

// File: test/ucg_peer_model.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------
// far-side clock peer
// ------------------
module ucg_peer_model #(parameter int HALF = 4) (
    input wire logic core_clk_i, // timing base
    input wire logic run_i, // run clock
    input wire logic idle_i, // idle level
    output logic xclk_o // transfer clock
);
    int cnt = 0;
    logic clk_r = 1'b0;
    assign xclk_o = clk_r;
    // period 2*HALF cycles, well under a quarter of the system rate
    always @(negedge core_clk_i) begin
        cnt <= (!run_i || cnt == HALF - 1) ? 0 : cnt + 1;
        if (!run_i) clk_r <= idle_i;
        else if (cnt == HALF - 1) clk_r <= !clk_r;
    end
endmodule // ucg_peer_model
`default_nettype wire

// File: test/ucg_clock_gen_properties.sv
`timescale 1ns/1ns
`default_nettype none
// ---------------
// port checks
// ---------------
module ucg_clock_gen_chk #(parameter int DIV_W = 12) (
    input wire logic core_clk_i, // clock
    input wire logic reset_i, // reset
    input wire logic sync_mode_select_i, // sync
    input wire logic double_rate_bit_i, // x2
    input wire logic transfer_clock_dir_i, // dir
    input wire logic clock_edge_polarity_i, // pol
    input wire logic [7:0] baud_divisor_low_i, // low
    input wire logic [3:0] baud_divisor_high_i, // high
    input wire logic baud_divisor_low_wr_i, // write
    input wire logic transfer_clock_pin_i, // pin
    input wire logic transfer_clock_pin_oe_o, // oe
    input wire logic [1:0] mode_o, // mode
    input wire logic baud_tick_o, // tick
    input wire logic tx_clk_en_o, // tx en
    input wire logic rx_sample_en_o, // rx en
    input wire logic [4:0] rx_states_o, // states
    input wire logic [DIV_W-1:0] baud_count_o // count
);
    // divisor as one word so $past sees a plain signal
    logic [DIV_W-1:0] div;
    logic ld;
    assign div = DIV_W'({baud_divisor_high_i, baud_divisor_low_i});
    assign ld = baud_count_o == '0 || baud_divisor_low_wr_i;
    default clocking dcb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    property p_oe; transfer_clock_pin_oe_o == (sync_mode_select_i && transfer_clock_dir_i); endproperty
    a_oe: assert property (p_oe) else $error("pin enable wrong");
    property p_mode; mode_o == {sync_mode_select_i, sync_mode_select_i ? !transfer_clock_dir_i : double_rate_bit_i}; endproperty
    a_mode: assert property (p_mode) else $error("mode wrong");
    property p_states; rx_states_o == (mode_o[1] ? 5'h02 : mode_o[0] ? 5'h08 : 5'h10); endproperty
    a_states: assert property (p_states) else $error("state count wrong");
    property p_reload; ld |=> baud_count_o == $past(div); endproperty
    a_reload: assert property (p_reload) else $error("no reload");
    property p_dec; !ld |=> baud_count_o == $past(baud_count_o) - 1'b1; endproperty
    a_dec: assert property (p_dec) else $error("no count down");
    property p_tick; baud_count_o == '0 && !baud_divisor_low_wr_i |=> baud_tick_o; endproperty
    a_tick: assert property (p_tick) else $error("tick missing");
    property p_notick; baud_count_o != '0 || baud_divisor_low_wr_i |=> !baud_tick_o; endproperty
    a_notick: assert property (p_notick) else $error("tick outside zero count");
    property p_txpulse; tx_clk_en_o |=> !tx_clk_en_o; endproperty
    a_txpulse: assert property (p_txpulse) else $error("tx enable held");
    property p_rxpulse; rx_sample_en_o |=> !rx_sample_en_o; endproperty
    a_rxpulse: assert property (p_rxpulse) else $error("rx enable held");
    property p_stx; mode_o == 2'b11 && $stable(clock_edge_polarity_i)
        && $rose(transfer_clock_pin_i ^ clock_edge_polarity_i) |-> ##[1:3] tx_clk_en_o; endproperty
    a_stx: assert property (p_stx) else $error("slave tx enable late");
    property p_srx; mode_o == 2'b11 && $stable(clock_edge_polarity_i)
        && $fell(transfer_clock_pin_i ^ clock_edge_polarity_i) |-> ##[1:3] rx_sample_en_o; endproperty
    a_srx: assert property (p_srx) else $error("slave rx enable late");
endmodule // ucg_clock_gen_chk
bind ucg_clock_gen ucg_clock_gen_chk #(.DIV_W(DIV_W)) chk_u (.core_clk_i, .reset_i, .sync_mode_select_i,
    .double_rate_bit_i, .transfer_clock_dir_i, .clock_edge_polarity_i, .baud_divisor_low_i,
    .baud_divisor_high_i, .baud_divisor_low_wr_i, .transfer_clock_pin_i, .transfer_clock_pin_oe_o,
    .mode_o, .baud_tick_o, .tx_clk_en_o, .rx_sample_en_o, .rx_states_o, .baud_count_o);
`default_nettype wire

// File: test/usart_clock_generation_test.sv
`timescale 1ns/1ns
`default_nettype none
module usart_clock_generation_test;
    logic clk = 1'b0, rst = 1'b1, sync = 1'b0, dbl = 1'b0, dir = 1'b0, pol = 1'b0, wr = 1'b0, run = 1'b0;
    logic pin, peer, pin_o, oe, tick, txen, rxen;
    logic [11:0] div = 12'h000, cnt;
    logic [1:0] mode;
    logic [4:0] states;
    int failures = 0, total_checks = 0, nt = 0, nr = 0;
    // ------------------
    // design and peer
    // ------------------
    // design drives the shared pin only while enabled
    assign pin = oe ? pin_o : peer;
    initial forever #5 clk = !clk;
    ucg_peer_model peer_u (.core_clk_i(clk), .run_i(run), .idle_i(pol), .xclk_o(peer));
    ucg_clock_gen dut_u (.core_clk_i(clk), .reset_i(rst), .sync_mode_select_i(sync), .double_rate_bit_i(dbl),
        .transfer_clock_dir_i(dir), .clock_edge_polarity_i(pol), .baud_divisor_low_i(div[7:0]),
        .baud_divisor_high_i(div[11:8]), .baud_divisor_low_wr_i(wr), .transfer_clock_pin_i(pin),
        .transfer_clock_pin_o(pin_o), .transfer_clock_pin_oe_o(oe), .mode_o(mode), .baud_tick_o(tick),
        .tx_clk_en_o(txen), .rx_sample_en_o(rxen), .rx_states_o(states), .baud_count_o(cnt));
    // enable pulses counted all the time, read as differences
    always @(posedge clk) begin
        nt <= nt + (txen === 1'b1);
        nr <= nr + (rxen === 1'b1);
    end
    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // nonblocking so the peer sees a clean change at the falling edge
    task automatic setup(bit s, bit d, bit r, bit p, logic [11:0] v);
        @(negedge clk);
        {sync, dbl, dir, pol, div, wr} <= {s, d, r, p, v, 1'b1};
        @(posedge clk);
        #1;
        check("count", {4'h0, cnt}, {4'h0, v});
        @(negedge clk);
        wr <= 1'b0;
    endtask
    // cycles and ticks up to the next tx enable or tick, bounded
    task automatic span(bit on_tx, output int cyc, output int tk);
        cyc = 0;
        tk = 0;
        do begin
            @(posedge clk);
            #1;
            cyc++;
            tk += (tick === 1'b1);
        end while ((on_tx ? txen : tick) !== 1'b1 && cyc < 20000);
        // a limit that runs out is a mismatch of its own
        if (cyc >= 20000) failures++;
    endtask
    task automatic mode_test(bit s, bit d, bit r, bit p, logic [11:0] v, logic [1:0] m, logic [4:0] st);
        int c, t, q;
        setup(s, d, r, p, v);
        check("mode", 16'(mode), 16'(m));
        check("states", 16'(states), 16'(st));
        check("oe", 16'(oe), 16'(m == 2'b10));
        span(1'b1, c, t);
        // master pin has just made its change edge; async keeps it idle
        check("pin", 16'(pin_o), 16'((m == 2'b10) ^ p));
        q = nr;
        span(1'b1, c, t);
        check("tx ticks", 16'(t), 16'(st));
        check("rx enables", 16'(nr - q), 16'(m == 2'b10));
        span(1'b0, c, t);
        span(1'b0, c, t);
        check("tick gap", 16'(c), {4'h0, v} + 16'h0001);
    endtask
    // peer gives 10 full periods, then idles
    task automatic slave_test(bit p);
        int a, b;
        setup(1'b1, 1'b0, 1'b0, p, 12'h007);
        repeat (8) @(negedge clk);
        a = nt;
        b = nr;
        run <= 1'b1;
        repeat (80) @(negedge clk);
        run <= 1'b0;
        repeat (12) @(negedge clk);
        check("slave tx", 16'(nt - a), 16'h000A);
        check("slave rx", 16'(nr - b), 16'h000A);
        check("slave oe", 16'({oe, mode}), 16'h0003);
    endtask
    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        slave_test(1'b0);
        slave_test(1'b1);
        mode_test(1'b0, 1'b0, 1'b0, 1'b0, 12'h003, 2'b00, 5'h10);
        mode_test(1'b0, 1'b1, 1'b1, 1'b0, 12'h000, 2'b01, 5'h08);
        mode_test(1'b1, 1'b0, 1'b1, 1'b0, 12'h005, 2'b10, 5'h02);
        mode_test(1'b1, 1'b0, 1'b1, 1'b1, 12'hFFF, 2'b10, 5'h02);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        check("reset count", {4'h0, cnt}, 16'h0000);
        check("reset pulses", 16'({tick, txen, rxen}), 16'h0000);
        end_sim;
    end
    // watchdog against a hang; about twice the expected run length
    initial begin
        #500000;
        failures++;
        end_sim;
    end
endmodule // usart_clock_generation_test
`default_nettype wire
